// ===== watchdog_sleep_config_unit.sv
// Watchdog, sleep control, start-up hold, configuration word and code-protected readout.
//
// What this block does
// - Low two configuration bits pick low-power, standard, high-speed crystal or RC.
// - Configuration bit 3 low turns code protection on.
// - Configuration bit 2 low disables the watchdog for good.
// - After every reset a hold timer keeps the device in reset for 18 ms.
// - Watchdog runs from its own time base and keeps counting during sleep.
// - A watchdog time-out causes a full device reset, running or asleep.
// - A watchdog time-out reset clears the timeout flag.
// - Without prescaler the watchdog period is 18 ms.
// - One 8-bit prescaler serves timer0 or the watchdog, never both.
// - Option bits 3 to 0 hold the assignment bit and the ratio field.
// - Assigned to the watchdog the prescaler divides up to 1:128.
// - Clear-watchdog clears the counter, and the prescaler when assigned to it.
// - Sleep clears the counter, and the prescaler when assigned to the watchdog.
// - Sleep entry sets timeout, clears powerdown and stops the oscillator driver.
// - During sleep all I/O pins keep their previous drive state.
// - A watchdog reset is internal and never drives the master-clear pin.
// - Sleep ends only on master-clear or enabled watchdog time-out, both full resets.
// - Powerdown flag is set at power-up and cleared only by sleep entry.
// - Waking from sleep always clears the watchdog counter.
// - With protection on, program reads above 0x3F return zero; 0x00-0x3F never protected.
// - User ID and configuration word stay readable and programmable under protection.
// - Four user ID words, reachable only in program/verify mode.
// - Assignment bit low gives the prescaler to timer0, high to the watchdog.
// - Any reset clears the prescaler; software cannot read or write it.
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "watchdog_sleep_defines.svh"

module watchdog_sleep_config_unit
  import watchdog_sleep_pkg::*;
#(
  parameter int HOLD_CYCLES = `HOLD_CYCLES_DEF,
  parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pins
  input wire logic master_clear_pin_n,
  input wire logic program_mode_pin,
  // Timer0 side of the shared prescaler
  input wire logic timer_count_en,
  input wire logic timer_write,
  output logic timer_scaled_tick,
  // Program memory readout
  input wire logic [10:0] pm_rd_addr,
  input wire logic [11:0] pm_rd_raw,
  output logic [11:0] pm_rd_data,
  // Device control
  output logic device_reset_n,
  output logic osc_driver_en,
  output logic io_hold,
  output osc_mode_type osc_mode
);

  // Returns 2**n - 1 as an 8-bit mask; used for both prescaler owners.
  function automatic logic [7:0] ratio_mask(input logic [3:0] n);
    logic [8:0] one_hot;
    one_hot = 9'h001 << n;
    return 8'(one_hot - 9'h001);
  endfunction : ratio_mask

  // Merges a 32-bit write into a narrower register under byte enables.
  function automatic logic [11:0] lane_merge(input logic [11:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [11:0] res;
    res = old_v;
    if (be[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      res[11:8] = new_v[11:8];
    end
    return res;
  endfunction : lane_merge

  unit_state_type state_q, state_d;
  config_word_type config_q;
  option_type option_q;
  logic [11:0] user_id_q [0:3];
  logic timeout_flag_q, powerdown_flag_q;
  logic [18:0] hold_count_q;
  logic [18:0] watchdog_counter_q;
  logic [7:0] prescaler_q;
  logic mclr_meta_q, mclr_sync_q, prog_meta_q, prog_sync_q;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic timer_scaled_tick_q;
  logic [11:0] pm_rd_data_q;
  logic device_reset_n_q, osc_driver_en_q, io_hold_q;
  osc_mode_type osc_mode_q;

  // Bus decode. One wait state: the answer comes on the cycle after the request is seen.
  wire bus_req = read | write;
  wire bus_grant = bus_req & waitrequest_q;
  wire bus_done = bus_req & ~waitrequest_q;
  wire wr_done = bus_done & write;
  wire hit_config = (address == `REG_CONFIG_WORD);
  wire hit_option = (address == `REG_OPTION);
  wire hit_status = (address == `REG_STATUS);
  wire hit_command = (address == `REG_COMMAND);
  wire hit_user_id = (address[5:4] == 2'(`REG_USER_ID0 >> 4));
  wire [1:0] user_idx = address[3:2];

  // Configuration and user ID locations are only reached in program/verify mode.
  wire prog_mode = prog_sync_q;
  wire clear_cmd = wr_done & hit_command & byteenable[0] & writedata[`CMD_CLEAR_WATCHDOG_BIT];
  wire sleep_cmd = wr_done & hit_command & byteenable[0] & writedata[`CMD_SLEEP_BIT];

  wire watchdog_on = config_q.watchdog_enable_fuse;
  wire protect_on = ~config_q.code_protect_fuse;
  wire presc_to_watchdog = option_q.prescaler_assign_bit;
  wire mclr_asserted = ~mclr_sync_q;

  wire in_hold = (state_q == st_hold);
  wire in_run = (state_q == st_run);
  wire in_sleep = (state_q == st_sleep);
  wire hold_done = (hold_count_q == 19'(HOLD_CYCLES - 1));

  // The watchdog counter free-runs on its own enable even while the core sleeps.
  wire watchdog_active = watchdog_on & ~in_hold;
  wire base_hit = watchdog_active & (watchdog_counter_q == 19'(WATCHDOG_CYCLES - 1));
  wire [7:0] watchdog_mask = ratio_mask({1'b0, option_q.prescale_ratio_field});
  wire [7:0] timer_mask = ratio_mask({1'b0, option_q.prescale_ratio_field} + 4'h1);
  wire watchdog_timeout = base_hit &
    (~presc_to_watchdog | ((prescaler_q & watchdog_mask) == watchdog_mask));

  // A sleep command that meets a time-out or a master-clear loses to the reset, so it must
  // not touch the flags or the counters either.
  wire sleep_entry = in_run & sleep_cmd & ~watchdog_timeout & ~mclr_asserted;
  wire clear_entry = in_run & clear_cmd;
  wire wake_event = in_sleep & (mclr_asserted | watchdog_timeout);

  // Reset sources go to hold; the master-clear pin is an input only, so a watchdog reset
  // never reaches it.
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_hold: begin
        if (!mclr_asserted && hold_done) begin
          state_d = st_run;
        end
      end
      st_run: begin
        if (mclr_asserted || watchdog_timeout) begin
          state_d = st_hold;
        end else if (sleep_cmd) begin
          state_d = st_sleep;
        end
      end
      st_sleep: begin
        if (wake_event) begin
          state_d = st_hold;
        end
      end
      default: begin
        state_d = st_hold;
      end
    endcase
  end

  // Two-flop synchronisers for the pins.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mclr_meta_q <= 1'b1;
      mclr_sync_q <= 1'b1;
      prog_meta_q <= 1'b0;
      prog_sync_q <= 1'b0;
    end else begin
      mclr_meta_q <= master_clear_pin_n;
      mclr_sync_q <= mclr_meta_q;
      prog_meta_q <= program_mode_pin;
      prog_sync_q <= prog_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= st_hold;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up hold timer restarts for every reset source, including a held master-clear.
  always_ff @(posedge clk) begin
    if (!rstn || !in_hold || mclr_asserted) begin
      hold_count_q <= 19'h00000;
    end else if (!hold_done) begin
      hold_count_q <= hold_count_q + 19'h00001;
    end
  end

  // Watchdog counter: cleared by reset hold, clear-watchdog, sleep entry, wake and every base-period end.
  always_ff @(posedge clk) begin
    if (!rstn || !watchdog_active || clear_entry || sleep_entry || wake_event || base_hit) begin
      watchdog_counter_q <= 19'h00000;
    end else begin
      watchdog_counter_q <= watchdog_counter_q + 19'h00001;
    end
  end

  // Shared prescaler; it has no bus address, so software can neither read nor load it.
  always_ff @(posedge clk) begin
    if (!rstn || in_hold) begin
      prescaler_q <= 8'h00;
    end else if (presc_to_watchdog) begin
      if (clear_entry || sleep_entry || watchdog_timeout) begin
        prescaler_q <= 8'h00;
      end else if (base_hit) begin
        prescaler_q <= prescaler_q + 8'h01;
      end
    end else if (timer_write) begin
      prescaler_q <= 8'h00;
    end else if (timer_count_en) begin
      prescaler_q <= prescaler_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || in_hold) begin
      timer_scaled_tick_q <= 1'b0;
    end else begin
      timer_scaled_tick_q <= ~presc_to_watchdog & timer_count_en & ~timer_write &
        ((prescaler_q & timer_mask) == timer_mask);
    end
  end

  // Status flags. Power-up sets both; time-out clears timeout; sleep sets timeout, clears
  // powerdown. A master-clear leaves both unchanged.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
    end else if (watchdog_timeout && !in_hold) begin
      timeout_flag_q <= 1'b0;
    end else if (sleep_entry) begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b0;
    end
  end

  // Option register reloads its reset value on every device reset.
  always_ff @(posedge clk) begin
    if (!rstn || in_hold) begin
      option_q <= option_type'(`OPT_RESET);
    end else if (wr_done && hit_option && byteenable[0]) begin
      option_q <= option_type'(writedata[5:0]);
    end
  end

  // The configuration word is a fuse: it survives device resets and is programmable only in
  // program/verify mode, whatever the protection setting.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      config_q <= config_word_type'(`CFG_ERASED);
    end else if (wr_done && hit_config && prog_mode) begin
      config_q <= config_word_type'(lane_merge(config_q, writedata, byteenable));
    end
  end

  always_ff @(posedge clk) begin
    if (wr_done && hit_user_id && prog_mode) begin
      user_id_q[user_idx] <= lane_merge(user_id_q[user_idx], writedata, byteenable);
    end
  end

  // Read multiplexer; unmapped or locked addresses read zero.
  wire [11:0] config_view = 12'(config_q) | `CFG_ONES_MASK;
  wire [31:0] status_view = {27'h0000000, timeout_flag_q, powerdown_flag_q, 2'b00, in_sleep};
  wire [31:0] read_mux =
    (hit_config && prog_mode) ? {20'h00000, config_view} :
    hit_status ? status_view :
    (hit_user_id && prog_mode) ? {20'h00000, user_id_q[user_idx]} :
    32'h00000000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end else begin
      waitrequest_q <= ~bus_grant;
      if (bus_grant && read) begin
        readdata_q <= read_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pm_rd_data_q <= 12'h000;
    end else if (protect_on && pm_rd_addr > `PROTECT_LIMIT) begin
      pm_rd_data_q <= 12'h000;
    end else begin
      pm_rd_data_q <= pm_rd_raw;
    end
  end

  // Device control outputs. The oscillator driver is off and the pins frozen while asleep.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      device_reset_n_q <= 1'b0;
      osc_driver_en_q <= 1'b1;
      io_hold_q <= 1'b0;
      osc_mode_q <= rc_oscillator;
    end else begin
      device_reset_n_q <= (state_d != st_hold);
      osc_driver_en_q <= (state_d != st_sleep);
      io_hold_q <= (state_d == st_sleep);
      osc_mode_q <= osc_mode_type'(config_q.osc_select_field);
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign timer_scaled_tick = timer_scaled_tick_q;
  assign pm_rd_data = pm_rd_data_q;
  assign device_reset_n = device_reset_n_q;
  assign osc_driver_en = osc_driver_en_q;
  assign io_hold = io_hold_q;
  assign osc_mode = osc_mode_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_fuse_blocks_timeout: assert property (!watchdog_on |-> !watchdog_timeout)
    else $error("Watchdog timed out with the enable fuse cleared.");
  a_timeout_full_reset: assert property (
    watchdog_timeout |=> !device_reset_n_q && in_hold)
    else $error("Watchdog time-out did not reset the device.");
  a_timeout_clears_flag: assert property (watchdog_timeout |=> !timeout_flag_q)
    else $error("Timeout flag not cleared by a watchdog reset.");
  a_sleep_entry_flags: assert property (sleep_entry |=> timeout_flag_q && !powerdown_flag_q
    && !osc_driver_en_q)
    else $error("Sleep entry flags or oscillator driver wrong.");
  a_sleep_pin_hold: assert property (
    sleep_entry |=> io_hold_q [*2] or (io_hold_q ##1 in_hold))
    else $error("Pins not held after sleep entry.");
  a_clear_zeroes_count: assert property (clear_entry && !base_hit |=> watchdog_counter_q == 19'h0
    && (!$past(presc_to_watchdog) || prescaler_q == 8'h00))
    else $error("Clear-watchdog did not clear the counter.");
  a_wake_clears_count: assert property (wake_event |=> watchdog_counter_q == 19'h0)
    else $error("Watchdog counter not cleared on wake.");
  a_protected_reads_zero: assert property (protect_on && pm_rd_addr > `PROTECT_LIMIT
    |=> pm_rd_data_q == 12'h000)
    else $error("Protected program word leaked.");
  a_low_reads_true: assert property (pm_rd_addr <= `PROTECT_LIMIT
    |=> pm_rd_data_q == $past(pm_rd_raw))
    else $error("Unprotected program word altered.");
  a_hold_clears_prescaler: assert property (in_hold |=> prescaler_q == 8'h00)
    else $error("Prescaler not cleared during reset.");
  a_hold_releases: assert property (in_hold && hold_done && !mclr_asserted
    |=> device_reset_n_q && in_run)
    else $error("Hold timer end did not release reset.");

  c_sleep_entered: cover property (sleep_entry);
  c_timeout_in_run: cover property (in_run && watchdog_timeout);
  c_timeout_wake: cover property (in_sleep && watchdog_timeout);
  c_clear_watchdog: cover property (clear_entry);

endmodule : watchdog_sleep_config_unit

// ===== watchdog_sleep_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog and sleep unit.
`ifndef WATCHDOG_SLEEP_DEFINES_SVH
`define WATCHDOG_SLEEP_DEFINES_SVH

`define REG_CONFIG_WORD 6'h00
`define REG_OPTION 6'h04
`define REG_STATUS 6'h08
`define REG_COMMAND 6'h0C
`define REG_USER_ID0 6'h10

`define CFG_OSC_LSB 0
`define CFG_WATCHDOG_EN_BIT 2
`define CFG_PROTECT_BIT 3
`define CFG_ONES_MASK 12'hFF0
`define CFG_ERASED 12'hFFF

`define OPT_ASSIGN_BIT 3
`define OPT_RESET 6'h3F

`define STAT_TIMEOUT_BIT 4
`define STAT_POWERDOWN_BIT 3
`define STAT_SLEEP_BIT 0

`define CMD_CLEAR_WATCHDOG_BIT 0
`define CMD_SLEEP_BIT 1

`define PROTECT_LIMIT 11'h03F

`define CLK_PERIOD_NS 50
`define HOLD_TIME_US 18000
`define WATCHDOG_BASE_US 18000
`define HOLD_CYCLES_DEF (`HOLD_TIME_US * 1000 / `CLK_PERIOD_NS)
`define WATCHDOG_CYCLES_DEF (`WATCHDOG_BASE_US * 1000 / `CLK_PERIOD_NS)

`endif

// ===== watchdog_sleep_pkg.sv
// Types shared by the watchdog, sleep and configuration unit.
package watchdog_sleep_pkg;

  typedef enum logic [1:0] {
    low_power_crystal,
    standard_crystal,
    high_speed_crystal,
    rc_oscillator
  } osc_mode_type;

  typedef enum logic [1:0] {
    st_hold,
    st_run,
    st_sleep
  } unit_state_type;

  typedef struct packed {
    logic [7:0] unused_ones;
    logic code_protect_fuse;
    logic watchdog_enable_fuse;
    logic [1:0] osc_select_field;
  } config_word_type;

  typedef struct packed {
    logic clock_source;
    logic clock_edge;
    logic prescaler_assign_bit;
    logic [2:0] prescale_ratio_field;
  } option_type;

endpackage : watchdog_sleep_pkg

// ===== testbench.sv
// Self-checking testbench for the watchdog, sleep and configuration unit.
`timescale 1ns/1ns
`include "watchdog_sleep_defines.svh"

module testbench;
  import watchdog_sleep_pkg::*;
  localparam int HOLD = 20;
  localparam int WD = 16;
  logic clk, rstn, read, write, master_clear_pin_n, program_mode_pin;
  logic timer_count_en, timer_write, timer_scaled_tick, waitrequest;
  logic device_reset_n, osc_driver_en, io_hold, low_seen;
  logic [5:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [10:0] pm_rd_addr;
  logic [11:0] pm_rd_raw, pm_rd_data;
  osc_mode_type osc_mode;
  int failures, compares;

  watchdog_sleep_config_unit #(.HOLD_CYCLES(HOLD), .WATCHDOG_CYCLES(WD))
    watchdog_sleep_config_unit_inst (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .master_clear_pin_n(master_clear_pin_n),
    .program_mode_pin(program_mode_pin), .timer_count_en(timer_count_en),
    .timer_write(timer_write), .timer_scaled_tick(timer_scaled_tick),
    .pm_rd_addr(pm_rd_addr), .pm_rd_raw(pm_rd_raw), .pm_rd_data(pm_rd_data),
    .device_reset_n(device_reset_n), .osc_driver_en(osc_driver_en), .io_hold(io_hold),
    .osc_mode(osc_mode));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic give_up(input string what);
    failures++;
    $display("[FAIL] %s expected answer seen none", what);
    complete_run();
  endtask : give_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Cycle counts carry a small tolerance because pipeline stages are the designer's choice.
  task automatic chk_near(input string what, input int exp, input int got);
    compares++;
    if (got < exp - 4 || got > exp + 4) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_near

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) give_up("bus answer");
      @(posedge clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    // One idle edge, so that a following call never reassigns a strobe in this time step.
    @(posedge clk);
  endtask : bus

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      if (device_reset_n === 1'b0) low_seen = 1'b1;
    end
  endtask : idle

  task automatic wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (device_reset_n !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) give_up("device reset level");
    end
  endtask : wait_rst

  task automatic t_power_up;
    int n;
    wait_rst(1'b1, 200, n);
    chk_near("hold length", HOLD + 1, n);
    rd_chk("status at power-up", `REG_STATUS, 32'h18);
    rd_chk("option readback", `REG_OPTION, 32'h0);
    rd_chk("unmapped read", 6'h3C, 32'h0);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_config;
    program_mode_pin <= 1'b1;
    idle(4);
    rd_chk("erased config", `REG_CONFIG_WORD, 32'hFFF);
    for (int m = 0; m < 4; m++) begin
      wr_reg(`REG_CONFIG_WORD, 32'h00C | m);
      rd_chk("config readback", `REG_CONFIG_WORD, 32'hFFC | m);
      idle(2);
      chk("osc mode", m, {30'h0, osc_mode});
    end
    program_mode_pin <= 1'b0;
    idle(4);
    rd_chk("config outside program mode", `REG_CONFIG_WORD, 32'h0);
    $display("test config done");
  endtask : t_config

  task automatic t_periods;
    logic [7:0] opt [4] = '{8'h08, 8'h0A, 8'h0F, 8'h07};
    int exp [4] = '{WD, WD * 4, WD * 128, WD};
    int n;
    for (int i = 0; i < 4; i++) begin
      // Clear first, so that a shorter ratio cannot expire on a half-counted period.
      wr_reg(`REG_COMMAND, 32'h1);
      wr_reg(`REG_OPTION, {24'h0, opt[i]});
      wr_reg(`REG_COMMAND, 32'h1);
      wait_rst(1'b0, 3000, n);
      chk_near("watchdog period", exp[i], n);
      wait_rst(1'b1, 200, n);
      rd_chk("status after time-out", `REG_STATUS, 32'h08);
    end
    $display("test periods done");
  endtask : t_periods

  task automatic t_clear;
    int n;
    wr_reg(`REG_OPTION, 32'h08);
    low_seen = 1'b0;
    repeat (8) begin
      wr_reg(`REG_COMMAND, 32'h1);
      idle(8);
    end
    chk("reset while cleared", 32'h0, {31'h0, low_seen});
    wr_reg(`REG_COMMAND, 32'h1);
    wait_rst(1'b0, 100, n);
    chk_near("period after last clear", WD, n);
    wait_rst(1'b1, 200, n);
    $display("test clear done");
  endtask : t_clear

  task automatic t_sleep;
    int n;
    wr_reg(`REG_OPTION, 32'h08);
    wr_reg(`REG_COMMAND, 32'h2);
    idle(2);
    chk("osc driver asleep", 32'h0, {31'h0, osc_driver_en});
    chk("pins frozen", 32'h1, {31'h0, io_hold});
    rd_chk("status asleep", `REG_STATUS, 32'h11);
    wait_rst(1'b0, 100, n);
    chk_near("sleep wake period", WD, n + 4);
    wait_rst(1'b1, 200, n);
    chk("osc driver awake", 32'h1, {31'h0, osc_driver_en});
    chk("pins released", 32'h0, {31'h0, io_hold});
    rd_chk("status after watchdog wake", `REG_STATUS, 32'h00);
    wr_reg(`REG_COMMAND, 32'h2);
    idle(3);
    master_clear_pin_n <= 1'b0;
    wait_rst(1'b0, 10, n);
    master_clear_pin_n <= 1'b1;
    wait_rst(1'b1, 200, n);
    rd_chk("status after master clear", `REG_STATUS, 32'h10);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_protect;
    int n;
    int ticks;
    program_mode_pin <= 1'b1;
    idle(4);
    wr_reg(`REG_CONFIG_WORD, 32'h003);
    rd_chk("protected config", `REG_CONFIG_WORD, 32'hFF3);
    pm_rd_addr <= 11'h03F;
    pm_rd_raw <= 12'hA5C;
    idle(2);
    chk("read at 0x3F", 32'hA5C, {20'h0, pm_rd_data});
    pm_rd_addr <= 11'h040;
    idle(2);
    chk("read at 0x40", 32'h0, {20'h0, pm_rd_data});
    for (int i = 0; i < 4; i++) begin
      wr_reg(6'(`REG_USER_ID0 + 4 * i), 32'hFF0 | i);
      rd_chk("user id", 6'(`REG_USER_ID0 + 4 * i), 32'hFF0 | i);
    end
    program_mode_pin <= 1'b0;
    idle(4);
    rd_chk("user id in run", `REG_USER_ID0, 32'h0);
    wr_reg(`REG_OPTION, 32'h00);
    timer_write <= 1'b1;
    idle(1);
    timer_write <= 1'b0;
    ticks = 0;
    for (int i = 0; i < 18; i++) begin
      timer_count_en <= (i < 16) && (i % 2 == 0);
      @(posedge clk);
      if (timer_scaled_tick === 1'b1) ticks++;
    end
    chk("timer ticks at 1:2", 32'h4, ticks);
    low_seen = 1'b0;
    wr_reg(`REG_OPTION, 32'h08);
    idle(100);
    wr_reg(`REG_COMMAND, 32'h2);
    idle(100);
    chk("reset with fuse off", 32'h0, {31'h0, low_seen});
    master_clear_pin_n <= 1'b0;
    wait_rst(1'b0, 10, n);
    master_clear_pin_n <= 1'b1;
    wait_rst(1'b1, 200, n);
    $display("test protect done");
  endtask : t_protect

  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    master_clear_pin_n = 1'b1;
    program_mode_pin = 1'b0;
    timer_count_en = 1'b0;
    timer_write = 1'b0;
    pm_rd_addr = 11'h000;
    pm_rd_raw = 12'h000;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_power_up();
    t_config();
    t_periods();
    t_clear();
    t_sleep();
    t_protect();
    complete_run();
  end
endmodule : testbench
